// ===== verilog/bio_ports.sv
/*
  Four bidirectional I/O ports (A, B, D eight lines, C seven lines) behind a classic Wishbone slave.
  Assumes the sharing subsystems sit elsewhere and present per-line direction and output values.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bio_cfg.svh"
module bio_ports (
  // Clock, reset, enable.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Wishbone slave.
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [`BIO_ADDR_W-1:0] adr_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       err_o,
  // Port A pins.
  input  wire logic [7:0]            port_a_i,
  output logic      [7:0]            port_a_o,
  output logic      [7:0]            port_a_oe_n_o,
  // Port B pins.
  input  wire logic [7:0]            port_b_i,
  output logic      [7:0]            port_b_o,
  output logic      [7:0]            port_b_oe_n_o,
  // Port C pins.
  input  wire logic [6:0]            port_c_i,
  output logic      [6:0]            port_c_o,
  output logic      [6:0]            port_c_oe_n_o,
  // Port D pins.
  input  wire logic [7:0]            port_d_i,
  output logic      [7:0]            port_d_o,
  output logic      [7:0]            port_d_oe_n_o,
  // Sharing subsystems: per-line claims, direction and output value.
  input  wire logic [7:0]            pwm_oe_i,
  input  wire logic [7:0]            pwm_out_i,
  input  wire logic [6:0]            adc_line_i,
  input  wire logic [7:0]            ssi_oe_i,
  input  wire logic [7:0]            ssi_out_i,
  input  wire logic [7:0]            osd_oe_i,
  input  wire logic [7:0]            osd_out_i,
  input  wire logic [7:0]            ssi_line_i,
  // Subsystem enables seen by the pins, and the accumulator input.
  output logic                       pulse_accum_enable_o,
  output logic                       pulse_accum_input_o,
  output logic [4:0]                 share_en_o
);
  import bio_pkg::*;

  logic [7:0]  share_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] rdat_q;
  logic        req;
  logic        wr;
  logic [3:0]  idx;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [7:0]  we_data;
  logic [7:0]  we_dir;
  logic [7:0]  rd_a;
  logic [7:0]  rd_b;
  logic [6:0]  rd_c;
  logic [7:0]  rd_d;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  logic [6:0]  dir_c;
  logic [7:0]  dir_d;
  logic [6:0]  sync_c;
  logic [7:0]  rsel;
  logic [6:0]  c_own;
  logic [7:0]  d_own;
  logic [7:0]  d_oe;
  logic [7:0]  d_out;

  assign req    = cyc_i && stb_i && !ack_q && !err_q;
  assign idx    = adr_i[`BIO_ADDR_W-1:2];
  assign mapped = (idx <= `BIO_IDX_SHARE) && (adr_i[1:0] == 2'b00);
  assign wr     = req && we_i && sel_i[0] && mapped && ce_i;
  assign wbyte  = dat_i[7:0];

  always_comb begin
    we_data = '0;
    we_dir  = '0;
    if (wr && !idx[3]) begin
      if (idx[2]) begin
        we_dir[idx[1:0]] = 1'b1;
      end else begin
        we_data[idx[1:0]] = 1'b1;
      end
    end
  end

  // Sharing control register: subsystem enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      share_q <= `BIO_SHARE_RST;
    end else if (wr && idx == `BIO_IDX_SHARE) begin
      share_q <= {3'h0, wbyte[4:0]};
    end
  end

  assign share_en_o           = share_q[4:0];
  assign pulse_accum_enable_o = share_q[`BIO_SH_PAM_EN];

  // Port A has no sharing subsystem.
  bio_pin_bank #(.W(8), .DRIVE(BIO_DRIVE_PUSH)) u_port_a (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .data_we_i  (we_data[0]),
    .dir_we_i   (we_dir[0]),
    .wdata_i    (wbyte),
    .sub_own_i  (8'h00),
    .sub_oe_i   (8'h00),
    .sub_out_i  (8'h00),
    .data_rd_o  (rd_a),
    .dir_rd_o   (dir_a),
    .pin_sync_o (),
    .pin_i      (port_a_i),
    .pin_o      (port_a_o),
    .pin_oe_n_o (port_a_oe_n_o)
  );

  bio_pin_bank #(.W(8), .DRIVE(BIO_DRIVE_OPEN_DRAIN)) u_port_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .data_we_i  (we_data[1]),
    .dir_we_i   (we_dir[1]),
    .wdata_i    (wbyte),
    .sub_own_i  ({8{share_q[`BIO_SH_PWM_EN]}}),
    .sub_oe_i   (pwm_oe_i),
    .sub_out_i  (pwm_out_i),
    .data_rd_o  (rd_b),
    .dir_rd_o   (dir_b),
    .pin_sync_o (),
    .pin_i      (port_b_i),
    .pin_o      (port_b_o),
    .pin_oe_n_o (port_b_oe_n_o)
  );

  // ADC lines become inputs; the accumulator line is an input when enabled.
  always_comb begin
    c_own = share_q[`BIO_SH_ADC_EN] ? adc_line_i : 7'h00;
    c_own[`BIO_PAM_LINE] = c_own[`BIO_PAM_LINE] | share_q[`BIO_SH_PAM_EN];
  end

  bio_pin_bank #(.W(7), .DRIVE(BIO_DRIVE_PUSH)) u_port_c (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .data_we_i  (we_data[2]),
    .dir_we_i   (we_dir[2]),
    .wdata_i    (wbyte[6:0]),
    .sub_own_i  (c_own),
    .sub_oe_i   (7'h00),
    .sub_out_i  (7'h00),
    .data_rd_o  (rd_c),
    .dir_rd_o   (dir_c),
    .pin_sync_o (sync_c),
    .pin_i      (port_c_i),
    .pin_o      (port_c_o),
    .pin_oe_n_o (port_c_oe_n_o)
  );

  // Accumulator input taken from the synchronised pin, zero when disabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_accum_input_o <= 1'b0;
    end else if (ce_i) begin
      pulse_accum_input_o <= share_q[`BIO_SH_PAM_EN] & sync_c[`BIO_PAM_LINE];
    end
  end

  // Serial lines take precedence over display lines when both claim one.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (share_q[`BIO_SH_SSI_EN] && ssi_line_i[i]) begin
        d_own[i] = 1'b1;
        d_oe[i]  = ssi_oe_i[i];
        d_out[i] = ssi_out_i[i];
      end else if (share_q[`BIO_SH_OSD_EN] && !ssi_line_i[i]) begin
        d_own[i] = 1'b1;
        d_oe[i]  = osd_oe_i[i];
        d_out[i] = osd_out_i[i];
      end else begin
        d_own[i] = 1'b0;
        d_oe[i]  = 1'b0;
        d_out[i] = 1'b0;
      end
    end
  end

  bio_pin_bank #(.W(8), .DRIVE(BIO_DRIVE_PUSH)) u_port_d (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .data_we_i  (we_data[3]),
    .dir_we_i   (we_dir[3]),
    .wdata_i    (wbyte),
    .sub_own_i  (d_own),
    .sub_oe_i   (d_oe),
    .sub_out_i  (d_out),
    .data_rd_o  (rd_d),
    .dir_rd_o   (dir_d),
    .pin_sync_o (),
    .pin_i      (port_d_i),
    .pin_o      (port_d_o),
    .pin_oe_n_o (port_d_oe_n_o)
  );

  always_comb begin
    case (idx)
      4'h0:    rsel = rd_a;
      4'h1:    rsel = rd_b;
      4'h2:    rsel = {1'b0, rd_c};
      4'h3:    rsel = rd_d;
      4'h4:    rsel = dir_a;
      4'h5:    rsel = dir_b;
      4'h6:    rsel = {1'b0, dir_c};
      4'h7:    rsel = dir_d;
      4'h8:    rsel = share_q;
      default: rsel = 8'h00;
    endcase
  end

  // One registered answer per request; unmapped addresses get err.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q  <= req && mapped;
      err_q  <= req && !mapped;
      rdat_q <= (req && mapped && !we_i) ? {24'h00_0000, rsel} : 32'h0000_0000;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdat_q;
endmodule
`default_nettype wire

// ===== include/bio_cfg.svh
/*
  Register offsets, field positions and reset values for the bidirectional I/O ports.
  Assumes a Wishbone byte-addressed slave whose register words are aligned on four bytes.
*/
`ifndef BIO_CFG_SVH
`define BIO_CFG_SVH

// Printed register indexes; the byte address is four times the index.
`define BIO_IDX_A_DATA   3'h0
`define BIO_IDX_B_DATA   3'h1
`define BIO_IDX_C_DATA   3'h2
`define BIO_IDX_D_DATA   3'h3
`define BIO_IDX_A_DIR    3'h4
`define BIO_IDX_B_DIR    3'h5
`define BIO_IDX_C_DIR    3'h6
`define BIO_IDX_D_DIR    3'h7
// Sharing control register, index 8.
`define BIO_IDX_SHARE    4'h8

`define BIO_PORT_W       8
`define BIO_PORT_C_W     7
`define BIO_ADDR_W       6
`define BIO_DIR_RST      8'h00
`define BIO_SHARE_RST    8'h00
`define BIO_PAM_LINE     4
// Bit positions inside the sharing control register.
`define BIO_SH_PAM_EN    0
`define BIO_SH_PWM_EN    1
`define BIO_SH_ADC_EN    2
`define BIO_SH_SSI_EN    3
`define BIO_SH_OSD_EN    4

`endif

// ===== include/bio_pkg.sv
/*
  Types shared by the bidirectional I/O port files.
  Assumes bio_cfg.svh is on the include path.
*/
`include "bio_cfg.svh"
package bio_pkg;
  typedef logic [`BIO_PORT_W-1:0] bio_byte_t;
  typedef enum logic [1:0] {
    BIO_DRIVE_PUSH,
    BIO_DRIVE_OPEN_DRAIN
  } bio_drive_t;
endpackage

// ===== verilog/bio_pin_bank.sv
/*
  One port of pin logic: data latch, direction, pin sampling, read mux and pin drive.
  Assumes pins arrive asynchronously and that latch writes come from the bus on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module bio_pin_bank #(
  parameter int              W     = 8,
  parameter bio_pkg::bio_drive_t DRIVE = bio_pkg::BIO_DRIVE_PUSH
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // Register writes.
  input  wire logic          data_we_i,
  input  wire logic          dir_we_i,
  input  wire logic [W-1:0]  wdata_i,
  // Per-line override by a sharing subsystem.
  input  wire logic [W-1:0]  sub_own_i,
  input  wire logic [W-1:0]  sub_oe_i,
  input  wire logic [W-1:0]  sub_out_i,
  // Register read views.
  output logic      [W-1:0]  data_rd_o,
  output logic      [W-1:0]  dir_rd_o,
  output logic      [W-1:0]  pin_sync_o,
  // Pins.
  input  wire logic [W-1:0]  pin_i,
  output logic      [W-1:0]  pin_o,
  output logic      [W-1:0]  pin_oe_n_o
);
  import bio_pkg::*;

  logic [W-1:0] latch_q;
  logic [W-1:0] dir_q;
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] drive_en;
  logic [W-1:0] drive_val;

  // The data latch has no reset so it keeps its contents across reset.
  always_ff @(posedge clk_i) begin
    if (ce_i && data_we_i) begin
      latch_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= W'(`BIO_DIR_RST);
    end else if (ce_i && dir_we_i) begin
      dir_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      drive_en[i]  = sub_own_i[i] ? sub_oe_i[i] : dir_q[i];
      drive_val[i] = sub_own_i[i] ? sub_out_i[i] : latch_q[i];
    end
  end

  // Pin outputs are registered and recomputed on each clock that has ce_i high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o      <= '0;
      pin_oe_n_o <= '1;
    end else if (ce_i) begin
      if (DRIVE == BIO_DRIVE_OPEN_DRAIN) begin
        pin_o      <= '0;
        pin_oe_n_o <= ~(drive_en & ~drive_val);
      end else begin
        pin_o      <= drive_val;
        pin_oe_n_o <= ~drive_en;
      end
    end
  end

  assign data_rd_o  = (dir_q & latch_q) | (~dir_q & sync_q);
  assign dir_rd_o   = dir_q;
  assign pin_sync_o = sync_q;
endmodule
`default_nettype wire

// ===== sim/bio_ports_assertions.sv
/*
  Concurrent checks on the bus answer and pin outputs of the port block.
  Assumes it is bound to bio_ports, sees only its ports, and that ce_i stays high.
*/
`timescale 1ns/100ps
`default_nettype none
module bio_ports_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic [7:0]  port_a_o,
  input wire logic [7:0]  port_a_oe_n_o,
  input wire logic [7:0]  port_b_o,
  input wire logic [7:0]  port_b_oe_n_o,
  input wire logic [6:0]  port_c_oe_n_o,
  input wire logic        pulse_accum_enable_o,
  input wire logic        pulse_accum_input_o,
  input wire logic [4:0]  share_en_o
);
  logic bad;
  assign bad = adr_i[5:2] > 4'h8 || adr_i[1:0] != 2'h0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && ce_i && !ack_o && !err_o;
  endsequence
  sequence s_wr_a;
    s_req ##0 (we_i && sel_i[0] && adr_i == 6'h00);
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_err_unmapped: assert property (s_req ##0 bad |=> err_o && !ack_o) else $error("no error answer");
  a_ack_mapped: assert property (s_req ##0 !bad |=> ack_o && !err_o) else $error("no ack answer");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  a_reset_clears: assert property ($fell(rst_i) |-> (&port_a_oe_n_o) && (&port_b_oe_n_o) && (&port_c_oe_n_o)
                                   && share_en_o == 5'h00) else $error("reset left a driver on");
  a_b_open_drain: assert property (port_b_o == 8'h00) else $error("port b drives high");
  a_write_drives: assert property (s_wr_a |-> ##2 ((port_a_o ^ $past(dat_i[7:0], 2)) & ~port_a_oe_n_o) == 8'h00)
    else $error("port a pin not updated");
  a_c_top_zero: assert property (ack_o && (adr_i[5:2] == 4'h2 || adr_i[5:2] == 4'h6) |-> !dat_o[7])
    else $error("port c top bit set");
  a_pam_idle: assert property (!pulse_accum_enable_o && $past(!pulse_accum_enable_o) |-> !pulse_accum_input_o)
    else $error("accumulator input while off");
  a_pam_line_in: assert property (pulse_accum_enable_o && $past(pulse_accum_enable_o) |-> port_c_oe_n_o[4])
    else $error("line 4 driven while accumulator on");
endmodule
`default_nettype wire

// ===== sim/bio_pin_model.sv
/*
  Board side of one port: each line follows the block where it drives, the board level elsewhere.
  Assumes ext_i holds the pull or board driver level of released lines.
*/
`timescale 1ns/100ps
`default_nettype none
module bio_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pin_o
);
  // A released open-drain line shows its pull-up through ext_i.
  assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule
`default_nettype wire

// ===== sim/bio_ports_tb.sv
/*
  Self-checking bench for the port block: Wishbone register calls, pin checks, sharing checks.
  Assumes the board model and the checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
module bio_ports_tb;
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
  logic        pulse_accum_enable_o, pulse_accum_input_o;
  logic [3:0]  sel_i;
  logic [4:0]  share_en_o;
  logic [5:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  port_a_i, port_a_o, port_a_oe_n_o, port_b_i, port_b_o, port_b_oe_n_o;
  logic [7:0]  port_d_i, port_d_o, port_d_oe_n_o, a_x, b_x, d_x, q;
  logic [7:0]  pwm_oe_i, pwm_out_i, ssi_oe_i, ssi_out_i, osd_oe_i, osd_out_i, ssi_line_i;
  logic [6:0]  port_c_i, port_c_o, port_c_oe_n_o, adc_line_i, c_x;
  int          errors, n_tests;

  bio_ports i_dut (.*);
  bio_pin_model #(.W(8)) i_pa (.out_i(port_a_o), .oe_n_i(port_a_oe_n_o), .ext_i(a_x), .pin_o(port_a_i));
  bio_pin_model #(.W(8)) i_pb (.out_i(port_b_o), .oe_n_i(port_b_oe_n_o), .ext_i(b_x), .pin_o(port_b_i));
  bio_pin_model #(.W(7)) i_pc (.out_i(port_c_o), .oe_n_i(port_c_oe_n_o), .ext_i(c_x), .pin_o(port_c_i));
  bio_pin_model #(.W(8)) i_pd (.out_i(port_d_o), .oe_n_i(port_d_oe_n_o), .ext_i(d_x), .pin_o(port_d_i));

  always #4 clk_i = ~clk_i;

  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One classic cycle; the request stands until ack or err is sampled high.
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {i, 2'h0};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
    q = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
  endtask

  initial begin
    {clk_i, cyc_i, stb_i, we_i, adr_i, dat_i, errors, n_tests} = '0;
    {rst_i, ce_i, sel_i} = 6'h3f;
    {pwm_oe_i, pwm_out_i, ssi_oe_i, ssi_out_i, osd_oe_i, osd_out_i, ssi_line_i, adc_line_i} = '0;
    {a_x, b_x, c_x, d_x} = {8'hc3, 8'hff, 7'h10, 8'h00};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 4; i < 8; i++) begin
      wb(1'b0, 4'(i), 8'h00);
      chk("dir_reset", 8'h00, q);
    end
    wb(1'b1, 4'h0, 8'h5a);
    wb(1'b0, 4'h0, 8'h00);
    chk("pa_input", 8'hc3, q);
    chk("pa_float", 8'hff, port_a_oe_n_o);
    wb(1'b1, 4'h4, 8'h0f);
    repeat (2) @(posedge clk_i);
    chk("pa_oe", 8'hf0, port_a_oe_n_o);
    chk("pa_pin", 8'h0a, port_a_o & 8'h0f);
    wb(1'b0, 4'h0, 8'h00);
    chk("pa_mixed", 8'hca, q);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h4, 8'h00);
    chk("pa_dir_rst", 8'h00, q);
    wb(1'b1, 4'h4, 8'hff);
    wb(1'b0, 4'h0, 8'h00);
    chk("pa_kept", 8'h5a, q);
    wb(1'b1, 4'h2, 8'hff);
    wb(1'b1, 4'h6, 8'hff);
    wb(1'b0, 4'h2, 8'h00);
    chk("pc_data", 8'h7f, q);
    wb(1'b0, 4'h6, 8'h00);
    chk("pc_dir", 8'h7f, q);
    wb(1'b1, 4'h1, 8'haa);
    wb(1'b1, 4'h5, 8'hff);
    wb(1'b1, 4'h3, 8'h3c);
    wb(1'b1, 4'h7, 8'hff);
    repeat (2) @(posedge clk_i);
    chk("pb_oe", 8'haa, port_b_oe_n_o);
    chk("pd_pin", 8'h3c, port_d_o);
    wb(1'b0, 4'h1, 8'h00);
    chk("pb_read", 8'haa, q);
    wb(1'b1, 4'h9, 8'h11);
    chk("err_wr", 8'h01, {7'h0, e});
    {pwm_oe_i, pwm_out_i, ssi_line_i} <= {8'hff, 8'h0f, 8'h01};
    wb(1'b1, 4'h8, 8'h0b);
    repeat (6) @(posedge clk_i);
    chk("pc4_in", 8'h01, {7'h0, port_c_oe_n_o[4]});
    chk("pam_in", 8'h01, {7'h0, pulse_accum_input_o});
    chk("pb_pwm", 8'h0f, port_b_oe_n_o);
    chk("pd_ssi", 8'h01, {7'h0, port_d_oe_n_o[0]});
    wb(1'b0, 4'h2, 8'h00);
    chk("pc_latch", 8'h7f, q);
    wb(1'b0, 4'h3, 8'h00);
    chk("pd_latch", 8'h3c, q);
    wb(1'b0, 4'h8, 8'h00);
    chk("share", 8'h0b, q);
    report_and_stop();
  end
endmodule
bind bio_ports bio_ports_assertions i_chk (.*);
`default_nettype wire
